// ### cpmb_core.sv
`timescale 1ns/1ps

// Summary of operation
// - six register views; user/system share one; others own stack, link, saved status
// - fast interrupt mode swaps in private general registers 8 to 12
// - wide 32-bit and compact 16-bit instruction streams are both fetched and run
// - exchanging branches switch instruction set from target address bit 0
// - five stages: fetch, decode/read, execute, memory, write-back
// - execute does alu or address; memory does data access
// - issue cycles are execute occupancy; branches 3, failed condition 1
// - alu results delay 0; single loads, coprocessor moves, swaps delay 1
// - register-shifted alu occupies execute 2 cycles, plain alu 1
// - alu writing the program counter takes 3 issue cycles, delay 0
// - load multiple occupies execute one cycle per word; last word delay 1
// - doubleword loads and coprocessor pair moves: 2 cycles, delays 0 then 1
// - 32-bit data buses to caches and coprocessors
// - up to 16 coprocessors selected by number
// - coprocessors work on their own; core pipeline never waits on them
// - core runs the 5TE instruction set including signal-processing extensions
// - branch with link writes next instruction address into the mode's link reg
module cpmb_core
    import cpmb_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic iss_valid,
    input wire cpmb_class_t iss_class,
    input wire logic iss_cond_pass,
    input wire logic iss_use_reg,
    input wire logic [3:0] iss_rd,
    input wire logic [3:0] iss_rn,
    input wire logic [3:0] iss_rm,
    input wire logic [4:0] iss_words,
    input wire logic [31:0] iss_imm,
    input wire logic [31:0] iss_pc,
    input wire logic [3:0] iss_cp_num,
    input wire logic [31:0] dc_rdata,
    input wire logic [31:0] cp_rdata,
    output logic iss_ready,
    output logic iss_ack,
    output logic [31:0] fetch_addr,
    output logic flush,
    output logic dc_req,
    output logic dc_we,
    output logic [31:0] dc_addr,
    output logic [31:0] dc_wdata,
    output logic cp_req,
    output logic [3:0] cp_num,
    output logic retire,
    output logic [31:0] status_word
);

    // ------------------------------------------------------------
    // bank selection helpers
    // ------------------------------------------------------------
    function automatic logic [2:0] bank_of(input logic [4:0] mode);
        case (mode)
            MODE_SUPERVISOR: bank_of = BANK_SVC;
            MODE_ABORT: bank_of = BANK_ABORT;
            MODE_UNDEFINED: bank_of = BANK_UNDEF;
            MODE_INTERRUPT: bank_of = BANK_IRQ;
            MODE_FAST_INTERRUPT: bank_of = BANK_FAST;
            default: bank_of = BANK_USER; // user, system and unknown codes share one view
        endcase
    endfunction : bank_of

    function automatic logic [4:0] phys_of(input logic [4:0] mode, input logic [3:0] r);
        logic [2:0] b;
        b = bank_of(mode);
        if (r < GEN_HIGH_FIRST)
            phys_of = {1'b0, r};
        else if (r < SP_INDEX)
            phys_of = (b == BANK_FAST) ? {1'b0, r} + FAST_HIGH_SHIFT : {1'b0, r};
        else
            phys_of = SP_LR_BASE + {1'b0, b, 1'b0} + {4'h0, r == LR_INDEX};
    endfunction : phys_of

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] regs [REG_COUNT];
    logic [31:0] saved_status_word [BANK_COUNT];
    logic [4:0] e_left;
    logic [4:0] e_step;
    cpmb_class_t e_class;
    logic e_cond;
    logic e_use_reg;
    logic [3:0] e_rd;
    logic [31:0] e_a;
    logic [31:0] e_s;
    logic [31:0] e_imm;
    logic [31:0] e_pc;
    logic [3:0] e_cp;
    logic m_load;
    logic m_from_cp;
    logic m_last;
    logic [4:0] m_widx;
    logic e_valid;
    logic e_first;
    logic e_last;
    logic taken;
    logic hazard;
    logic [4:0] rd_mode;
    logic [4:0] issue_cycles;
    logic [4:0] next_e_left;
    logic [31:0] alu_res;
    logic [31:0] insn_bytes;
    logic e_loads_now;
    logic [4:0] e_lidx;
    logic e_wen;
    logic [4:0] e_widx;
    logic [31:0] e_wdata;
    logic m_wen;
    logic [31:0] m_wdata;
    logic [31:0] opnd_a;
    logic [31:0] opnd_s;
    logic redirect;
    logic [31:0] target;

    assign e_valid = (e_left != 5'h00);
    assign e_first = e_valid && (e_step == 5'h00);
    assign e_last = (e_left == 5'h01);
    assign insn_bytes = status_word[COMPACT_BIT] ? COMPACT_INSN_BYTES : WIDE_INSN_BYTES;

    // a mode change retiring now must steer the operand read of the next instruction
    assign rd_mode = (e_last && e_cond && e_class == CPMB_MODE_SET) ?
        e_imm[4:0] : status_word[4:0];

    // ------------------------------------------------------------
    // execute stage datapath: shift plus alu, or address
    // ------------------------------------------------------------
    always_comb
    begin
        if (e_class == CPMB_ALU_REGSHIFT)
            alu_res = e_a + (e_imm << e_s[4:0]);
        else
            alu_res = e_a + (e_use_reg ? e_s : e_imm);
    end

    // write port from execute: alu results and the link address
    always_comb
    begin
        e_wen = 1'b0;
        e_widx = phys_of(status_word[4:0], e_rd);
        e_wdata = alu_res;
        if (e_valid && e_cond)
        begin
            if (e_last && (e_class == CPMB_ALU || e_class == CPMB_ALU_REGSHIFT))
                e_wen = 1'b1;
            else if (e_first && e_class == CPMB_BRANCH_LINK)
            begin
                e_wen = 1'b1;
                e_widx = phys_of(status_word[4:0], LR_INDEX);
                e_wdata = e_pc + insn_bytes;
            end
        end
    end

    // the word handled in this execute cycle lands in a register one cycle later
    always_comb
    begin
        case (e_class)
            CPMB_LOAD, CPMB_CP_TO_CORE: e_loads_now = e_first;
            CPMB_LOAD_MULT, CPMB_LOAD_DBL, CPMB_CP_PAIR: e_loads_now = 1'b1;
            CPMB_SWAP: e_loads_now = (e_step == 5'h01); // store first, load last
            default: e_loads_now = 1'b0;
        endcase
        e_loads_now = e_loads_now && e_valid && e_cond;
        // swap reads back into rd itself, not into the next register
        e_lidx = phys_of(status_word[4:0], e_rd + ((e_class == CPMB_SWAP) ? 4'h0 : e_step[3:0]));
    end

    // memory stage returns data in the same cycle as the request
    assign m_wen = m_load;
    assign m_wdata = m_from_cp ? cp_rdata : dc_rdata;

    // ------------------------------------------------------------
    // decode: operand read with bypass, load-use interlock
    // ------------------------------------------------------------
    function automatic logic [31:0] read_opnd(input logic [3:0] r, input logic [4:0] mode,
        input logic ew, input logic [4:0] ei, input logic [31:0] ed,
        input logic mw, input logic [4:0] mi, input logic [31:0] md);
        logic [4:0] idx;
        idx = phys_of(mode, r);
        read_opnd = regs[idx];
        if (mw && mi == idx)
            read_opnd = md;
        if (ew && ei == idx)
            read_opnd = ed;
        if (r == PC_INDEX)
            read_opnd = iss_pc;
    endfunction : read_opnd

    always_comb
    begin
        opnd_a = read_opnd(iss_rn, rd_mode, e_wen, e_widx, e_wdata, m_wen, m_widx, m_wdata);
        opnd_s = read_opnd(iss_rm, rd_mode, e_wen, e_widx, e_wdata, m_wen, m_widx, m_wdata);
        // a word fetched in the final execute cycle is one cycle late for its reader
        hazard = e_last && e_loads_now &&
            ((iss_rn != PC_INDEX && phys_of(rd_mode, iss_rn) == e_lidx) ||
             (iss_rm != PC_INDEX && phys_of(rd_mode, iss_rm) == e_lidx));
        taken = iss_valid && iss_ready && !hazard;
    end

    // execute occupancy per class
    always_comb
    begin
        case (iss_class)
            CPMB_ALU_REGSHIFT: issue_cycles = ISSUE_REG_SHIFT;
            CPMB_ALU_PC: issue_cycles = ISSUE_PC_WRITE;
            CPMB_BRANCH, CPMB_BRANCH_LINK, CPMB_BRANCH_EXCH: issue_cycles = ISSUE_PC_WRITE;
            CPMB_LOAD_MULT:
                issue_cycles = (iss_words == 5'h00) ? ISSUE_SINGLE : iss_words;
            CPMB_LOAD_DBL, CPMB_CP_PAIR, CPMB_SWAP: issue_cycles = ISSUE_PAIR;
            CPMB_MODE_SET: issue_cycles = ISSUE_MODE_SET;
            default: issue_cycles = ISSUE_SINGLE;
        endcase
        if (!iss_cond_pass)
            issue_cycles = ISSUE_SINGLE;
        if (taken)
            next_e_left = issue_cycles;
        else if (e_valid)
            next_e_left = e_left - 5'h01;
        else
            next_e_left = 5'h00;
    end

    // ------------------------------------------------------------
    // execute stage registers, five-stage handshake
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            e_left <= 5'h00;
            e_step <= 5'h00;
            iss_ready <= 1'b1;
            iss_ack <= 1'b0;
        end
        else
        begin
            e_left <= next_e_left;
            e_step <= taken ? 5'h00 : e_step + 5'h01;
            iss_ready <= (next_e_left <= ISSUE_SINGLE);
            iss_ack <= taken;
        end
    end

    // operands are captured with the instruction; no reset needed on datapath
    always_ff @(posedge clk)
    begin
        if (taken)
        begin
            e_class <= iss_class;
            e_cond <= iss_cond_pass;
            e_use_reg <= iss_use_reg;
            e_rd <= iss_rd;
            e_a <= opnd_a;
            e_s <= opnd_s;
            e_imm <= iss_imm;
            e_pc <= iss_pc;
            e_cp <= iss_cp_num;
        end
    end

    // ------------------------------------------------------------
    // memory stage: data cache and coprocessor requests
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dc_req <= 1'b0;
            dc_we <= 1'b0;
            dc_addr <= 32'h00000000;
            dc_wdata <= 32'h00000000;
            cp_req <= 1'b0;
            cp_num <= 4'h0;
            m_load <= 1'b0;
            m_from_cp <= 1'b0;
            m_last <= 1'b0;
            m_widx <= 5'h00;
            retire <= 1'b0;
        end
        else
        begin
            dc_req <= e_valid && e_cond && (e_class inside {CPMB_LOAD, CPMB_LOAD_MULT,
                CPMB_LOAD_DBL, CPMB_STORE, CPMB_SWAP});
            dc_we <= (e_class == CPMB_STORE) || (e_class == CPMB_SWAP && e_first);
            // swap stores and loads one address; block transfers step by a word
            dc_addr <= e_a + e_imm +
                ((e_class == CPMB_SWAP) ? 32'h00000000 : {25'h0000000, e_step, 2'b00});
            dc_wdata <= e_s;
            // coprocessor is only sampled here; the core never waits for it
            cp_req <= e_valid && e_cond &&
                (e_class == CPMB_CP_TO_CORE || e_class == CPMB_CP_PAIR);
            cp_num <= e_cp;
            m_load <= e_loads_now;
            m_from_cp <= (e_class == CPMB_CP_TO_CORE || e_class == CPMB_CP_PAIR);
            m_widx <= e_lidx;
            m_last <= e_valid && e_last;
            retire <= m_last; // write-back stage completes
        end
    end

    // ------------------------------------------------------------
    // register file: two write ports, execute wins as the younger
    // ------------------------------------------------------------
    for (genvar i = 0; i < REG_COUNT; i++)
    begin : g_reg
        always_ff @(posedge clk or negedge reset_n)
        begin
            if (!reset_n)
                regs[i] <= 32'h00000000;
            else if (e_wen && e_widx == 5'(i))
                regs[i] <= e_wdata;
            else if (m_wen && m_widx == 5'(i))
                regs[i] <= m_wdata;
        end
    end

    // ------------------------------------------------------------
    // program counter redirect and instruction-set switch
    // ------------------------------------------------------------
    always_comb
    begin
        redirect = e_first && e_cond && (e_class inside {CPMB_BRANCH, CPMB_BRANCH_LINK,
            CPMB_BRANCH_EXCH, CPMB_ALU_PC});
        case (e_class)
            CPMB_BRANCH_EXCH: target = {e_s[31:1], 1'b0};
            CPMB_ALU_PC: target = alu_res;
            default: target = e_pc + e_imm;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fetch_addr <= FETCH_RESET;
            flush <= 1'b0;
        end
        else
        begin
            flush <= redirect; // refill happens under the remaining issue cycles
            if (redirect)
                fetch_addr <= target;
            else if (taken)
                fetch_addr <= fetch_addr + insn_bytes;
        end
    end

    // status word: instruction-set bit and mode; saved copy per banked mode
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            status_word <= STATUS_RESET;
        else if (redirect && e_class == CPMB_BRANCH_EXCH)
            status_word[COMPACT_BIT] <= e_s[0];
        else if (e_last && e_cond && e_class == CPMB_MODE_SET)
            status_word[MODE_LSB +: 5] <= e_imm[4:0];
    end

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            for (int k = 0; k < BANK_COUNT; k++)
                saved_status_word[k] <= 32'h00000000;
        end
        else if (e_valid && e_last && e_cond && e_class == CPMB_MODE_SET &&
                 bank_of(e_imm[4:0]) != BANK_USER)
            saved_status_word[bank_of(e_imm[4:0])] <= status_word;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_busy_two;
        !iss_ready ##1 !iss_ready ##1 iss_ready;
    endsequence

    property p_branch_issue;
        @(posedge clk) disable iff (!reset_n)
        taken && iss_cond_pass && iss_class == CPMB_BRANCH |=> s_busy_two;
    endproperty
    a_branch_issue: assert property (p_branch_issue) else $error("branch not 3 issue cycles");

    property p_cond_fail;
        @(posedge clk) disable iff (!reset_n)
        taken && !iss_cond_pass |=> iss_ready ##1 !flush;
    endproperty
    a_cond_fail: assert property (p_cond_fail) else $error("failed condition not 1 cycle");

    property p_regshift;
        @(posedge clk) disable iff (!reset_n)
        taken && iss_cond_pass && iss_class == CPMB_ALU_REGSHIFT |=> !iss_ready ##1 iss_ready;
    endproperty
    a_regshift: assert property (p_regshift) else $error("shifted alu not 2 cycles");

    property p_alu_pc;
        @(posedge clk) disable iff (!reset_n)
        taken && iss_cond_pass && iss_class == CPMB_ALU_PC |=> s_busy_two and (##1 flush);
    endproperty
    a_alu_pc: assert property (p_alu_pc) else $error("pc-writing alu timing wrong");

    property p_ldm_len;
        @(posedge clk) disable iff (!reset_n)
        taken && iss_cond_pass && iss_class == CPMB_LOAD_MULT && iss_words != 5'h00
            |=> e_left == $past(iss_words);
    endproperty
    a_ldm_len: assert property (p_ldm_len) else $error("load multiple occupancy wrong");

    property p_load_use;
        @(posedge clk) disable iff (!reset_n)
        e_last && e_loads_now && iss_valid && iss_rn != PC_INDEX &&
            phys_of(rd_mode, iss_rn) == e_lidx |-> !taken;
    endproperty
    a_load_use: assert property (p_load_use) else $error("load result used too early");

    property p_dbl;
        @(posedge clk) disable iff (!reset_n)
        taken && iss_cond_pass && (iss_class == CPMB_LOAD_DBL || iss_class == CPMB_CP_PAIR)
            |=> !iss_ready ##1 iss_ready;
    endproperty
    a_dbl: assert property (p_dbl) else $error("doubleword not 2 cycles");

    property p_link;
        @(posedge clk) disable iff (!reset_n)
        e_first && e_cond && e_class == CPMB_BRANCH_LINK |=>
            regs[phys_of(status_word[4:0], LR_INDEX)] == $past(e_pc) + $past(insn_bytes);
    endproperty
    a_link: assert property (p_link) else $error("link register not written");

    property p_fast_bank;
        @(posedge clk) disable iff (!reset_n)
        bank_of(status_word[4:0]) == BANK_FAST && !m_wen |=> $stable(regs[8]);
    endproperty
    a_fast_bank: assert property (p_fast_bank) else $error("shared r8 hit in fast mode");

    property p_exch;
        @(posedge clk) disable iff (!reset_n)
        e_first && e_cond && e_class == CPMB_BRANCH_EXCH |=>
            status_word[COMPACT_BIT] == $past(e_s[0]);
    endproperty
    a_exch: assert property (p_exch) else $error("instruction set not switched");

    property p_mode_switch;
        @(posedge clk) disable iff (!reset_n)
        taken && iss_cond_pass && iss_class == CPMB_MODE_SET |->
            ##4 status_word[4:0] == $past(iss_imm[4:0], 4);
    endproperty
    a_mode_switch: assert property (p_mode_switch) else $error("mode not switched");

    property p_mem_after_exec;
        @(posedge clk) disable iff (!reset_n)
        dc_req |-> $past(e_valid);
    endproperty
    a_mem_after_exec: assert property (p_mem_after_exec) else $error("stray memory req");

endmodule : cpmb_core

// ### cpmb_pkg.sv
package cpmb_pkg;

    // ------------------------------------------------------------
    // processor mode codes held in the low bits of the status word
    // ------------------------------------------------------------
    localparam logic [4:0] MODE_USER = 5'h10;
    localparam logic [4:0] MODE_FAST_INTERRUPT = 5'h11;
    localparam logic [4:0] MODE_INTERRUPT = 5'h12;
    localparam logic [4:0] MODE_SUPERVISOR = 5'h13;
    localparam logic [4:0] MODE_ABORT = 5'h17;
    localparam logic [4:0] MODE_UNDEFINED = 5'h1b;
    localparam logic [4:0] MODE_SYSTEM = 5'h1f;

    // ------------------------------------------------------------
    // bank numbers, physical register layout, status word fields
    // ------------------------------------------------------------
    localparam logic [2:0] BANK_USER = 3'h0;
    localparam logic [2:0] BANK_SVC = 3'h1;
    localparam logic [2:0] BANK_ABORT = 3'h2;
    localparam logic [2:0] BANK_UNDEF = 3'h3;
    localparam logic [2:0] BANK_IRQ = 3'h4;
    localparam logic [2:0] BANK_FAST = 3'h5;
    localparam int BANK_COUNT = 6;
    localparam int REG_COUNT = 30;
    localparam logic [4:0] FAST_HIGH_SHIFT = 5'h05;
    localparam logic [4:0] SP_LR_BASE = 5'h12;
    localparam logic [3:0] GEN_HIGH_FIRST = 4'h8;
    localparam logic [3:0] SP_INDEX = 4'hd;
    localparam logic [3:0] LR_INDEX = 4'he;
    localparam logic [3:0] PC_INDEX = 4'hf;
    localparam int MODE_LSB = 0;
    localparam int COMPACT_BIT = 5;
    localparam logic [31:0] STATUS_RESET = 32'h00000013;
    localparam logic [31:0] FETCH_RESET = 32'h00000000;
    localparam logic [31:0] WIDE_INSN_BYTES = 32'h00000004;
    localparam logic [31:0] COMPACT_INSN_BYTES = 32'h00000002;

    // ------------------------------------------------------------
    // cycles spent in execute per instruction class
    // ------------------------------------------------------------
    localparam logic [4:0] ISSUE_SINGLE = 5'h01;
    localparam logic [4:0] ISSUE_REG_SHIFT = 5'h02;
    localparam logic [4:0] ISSUE_PC_WRITE = 5'h03;
    localparam logic [4:0] ISSUE_PAIR = 5'h02;
    localparam logic [4:0] ISSUE_MODE_SET = 5'h03;

    typedef enum logic [3:0] {
        CPMB_ALU = 4'h0,
        CPMB_ALU_REGSHIFT = 4'h1,
        CPMB_ALU_PC = 4'h2,
        CPMB_BRANCH = 4'h3,
        CPMB_BRANCH_LINK = 4'h4,
        CPMB_BRANCH_EXCH = 4'h5,
        CPMB_LOAD = 4'h6,
        CPMB_LOAD_MULT = 4'h7,
        CPMB_LOAD_DBL = 4'h8,
        CPMB_STORE = 4'h9,
        CPMB_SWAP = 4'ha,
        CPMB_CP_TO_CORE = 4'hb,
        CPMB_CP_PAIR = 4'hc,
        CPMB_MODE_SET = 4'hd,
        CPMB_NOP = 4'he
    } cpmb_class_t;

endpackage : cpmb_pkg

// ### cpmb_mem_model.sv
`timescale 1ns/1ps

// -----------------------------------
// cache and coprocessor stand-in
// -----------------------------------
module cpmb_mem_model (
    input wire logic clk,
    input wire logic dc_req,
    input wire logic [31:0] dc_addr,
    input wire logic cp_req,
    input wire logic [3:0] cp_num,
    output logic [31:0] dc_rdata,
    output logic [31:0] cp_rdata
);
    logic [31:0] churn = 32'h0;
    // idle buses change every cycle so stale data never looks valid
    always @(posedge clk) churn <= churn + 32'h9e3779b9;
    // same-cycle answers on full-width buses
    assign dc_rdata = dc_req ? (dc_addr ^ 32'h5a5a0000) : churn;
    // every coprocessor number answers its own word, no stall
    assign cp_rdata = cp_req ? {28'h0010000, cp_num} : ~churn;
endmodule : cpmb_mem_model

// ### cpmb_core_tb.sv
`timescale 1ns/1ps

module cpmb_core_tb
    import cpmb_pkg::*;
;
    logic clk, reset_n, iss_valid, iss_cond_pass, iss_use_reg, cond, ureg;
    cpmb_class_t iss_class;
    logic [3:0] iss_rd, iss_rn, iss_rm, iss_cp_num, cp_num, cp_seen, cpn;
    logic [4:0] iss_words, words;
    logic [31:0] iss_imm, iss_pc, dc_rdata, cp_rdata, fetch_addr, dc_addr, dc_wdata;
    logic [31:0] status_word, st_data, target;
    logic iss_ready, iss_ack, flush, dc_req, dc_we, cp_req, retire;
    int mismatches, check_count, issued, retires, cycles;

    cpmb_core u_dut (.clk(clk), .reset_n(reset_n), .iss_valid(iss_valid),
        .iss_class(iss_class), .iss_cond_pass(iss_cond_pass), .iss_use_reg(iss_use_reg),
        .iss_rd(iss_rd), .iss_rn(iss_rn), .iss_rm(iss_rm), .iss_words(iss_words),
        .iss_imm(iss_imm), .iss_pc(iss_pc), .iss_cp_num(iss_cp_num), .dc_rdata(dc_rdata),
        .cp_rdata(cp_rdata), .iss_ready(iss_ready), .iss_ack(iss_ack),
        .fetch_addr(fetch_addr), .flush(flush), .dc_req(dc_req), .dc_we(dc_we),
        .dc_addr(dc_addr), .dc_wdata(dc_wdata), .cp_req(cp_req), .cp_num(cp_num),
        .retire(retire), .status_word(status_word));
    cpmb_mem_model u_mem (.clk(clk), .dc_req(dc_req), .dc_addr(dc_addr),
        .cp_req(cp_req), .cp_num(cp_num), .dc_rdata(dc_rdata), .cp_rdata(cp_rdata));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // capture one-cycle pulses mid-cycle, where they have settled
    always @(negedge clk)
    begin
        if (dc_req && dc_we) st_data = dc_wdata;
        if (flush) target = fetch_addr;
        if (retire) retires++;
        if (cp_req) cp_seen = cp_num;
    end

    // hang guard: the whole run needs under two hundred cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask : chk

    // offer one instruction, hold it until taken, then time its execute stay
    task automatic issue(input cpmb_class_t c, input logic [3:0] rd, input logic [3:0] rm,
        input logic [31:0] pc, input logic [31:0] imm, input logic [31:0] exp_cyc);
        int n;
        n = 1;
        @(posedge clk);
        iss_valid <= 1'b1;
        iss_class <= c;
        iss_cond_pass <= cond;
        iss_use_reg <= ureg;
        iss_rd <= rd;
        iss_rn <= 4'hf;
        iss_rm <= rm;
        iss_words <= words;
        iss_imm <= imm;
        iss_pc <= pc;
        iss_cp_num <= cpn;
        do
            @(negedge clk);
        while (iss_ready !== 1'b1);
        @(posedge clk);
        iss_valid <= 1'b0;
        issued++;
        @(negedge clk);
        chk("ack", 32'h1, {31'h0, iss_ack});
        while (iss_ready !== 1'b1 && n < 40)
        begin
            n++;
            @(negedge clk);
        end
        chk("issue cycles", exp_cyc, 32'(n));
    endtask : issue

    // a store exposes a register on the write data bus
    task automatic store_chk(input logic [3:0] rd, input logic [31:0] exp);
        st_data = 32'hx;
        issue(CPMB_STORE, 4'h0, rd, 32'h300, 32'h0, 32'h1);
        repeat (2) @(negedge clk);
        chk("stored reg", exp, st_data);
    endtask : store_chk

    task automatic t_alu;
        issue(CPMB_ALU, 4'h1, 4'hf, 32'h100, 32'h5, 32'h1);
        store_chk(4'h1, 32'h105);
        ureg = 1'b1;
        issue(CPMB_ALU, 4'h5, 4'hf, 32'h80, 32'h0, 32'h1);
        ureg = 1'b0;
        store_chk(4'h5, 32'h100);
        issue(CPMB_ALU_REGSHIFT, 4'h4, 4'hf, 32'h10, 32'h1, 32'h2);
        store_chk(4'h4, 32'h10010);
    endtask : t_alu

    task automatic t_flow;
        issue(CPMB_BRANCH, 4'h0, 4'h0, 32'h400, 32'h20, 32'h3);
        chk("target", 32'h420, target);
        cond = 1'b0;
        issue(CPMB_BRANCH, 4'h0, 4'h0, 32'h600, 32'h20, 32'h1);
        cond = 1'b1;
        chk("target", 32'h420, target);
        issue(CPMB_ALU_PC, PC_INDEX, 4'h0, 32'h700, 32'h8, 32'h3);
        chk("target", 32'h708, target);
        issue(CPMB_BRANCH_LINK, 4'h0, 4'h0, 32'h500, 32'h8, 32'h3);
        store_chk(LR_INDEX, 32'h504);
        issue(CPMB_BRANCH_EXCH, 4'h0, 4'hf, 32'h901, 32'h0, 32'h3);
        chk("compact", 32'h1, {31'h0, status_word[COMPACT_BIT]});
        chk("target", 32'h900, target);
    endtask : t_flow

    task automatic t_mem;
        issue(CPMB_LOAD, 4'h2, 4'h0, 32'h200, 32'h40, 32'h1);
        store_chk(4'h2, 32'h5a5a0240);
        issue(CPMB_LOAD_MULT, 4'h8, 4'h0, 32'h200, 32'h0, 32'h4);
        store_chk(4'hb, 32'h5a5a020c);
        issue(CPMB_LOAD_DBL, 4'h0, 4'h0, 32'h200, 32'h10, 32'h2);
        store_chk(4'h1, 32'h5a5a0214);
        issue(CPMB_CP_TO_CORE, 4'h3, 4'h0, 32'h0, 32'h0, 32'h1);
        store_chk(4'h3, 32'h00100009);
        chk("cp number", 32'h9, {28'h0, cp_seen});
        issue(CPMB_CP_PAIR, 4'h6, 4'h0, 32'h0, 32'h0, 32'h2);
        issue(CPMB_SWAP, 4'h9, 4'h2, 32'h200, 32'h0, 32'h2);
        store_chk(4'h9, 32'h5a5a0200);
    endtask : t_mem

    // a reader offered right behind a load is held off one cycle
    task automatic t_hazard;
        @(posedge clk);
        iss_valid <= 1'b1;
        iss_class <= CPMB_LOAD;
        iss_cond_pass <= 1'b1;
        iss_rd <= 4'h2;
        iss_imm <= 32'h44;
        iss_pc <= 32'h200;
        @(posedge clk);
        iss_class <= CPMB_ALU;
        iss_rd <= 4'h3;
        iss_rn <= 4'h2;
        iss_imm <= 32'h0;
        repeat (2) @(negedge clk);
        chk("ack held", 32'h0, {31'h0, iss_ack});
        @(posedge clk);
        iss_valid <= 1'b0;
        issued += 2;
        store_chk(4'h3, 32'h5a5a0244);
    endtask : t_hazard

    task automatic t_bank;
        issue(CPMB_ALU, 4'h8, 4'h0, 32'h800, 32'h1, 32'h1);
        issue(CPMB_ALU, SP_INDEX, 4'h0, 32'h900, 32'h1, 32'h1);
        issue(CPMB_MODE_SET, 4'h0, 4'h0, 32'h0, {27'h0, MODE_FAST_INTERRUPT}, 32'h3);
        issue(CPMB_ALU, 4'h8, 4'h0, 32'ha00, 32'h1, 32'h1);
        chk("mode", {27'h0, MODE_FAST_INTERRUPT}, {27'h0, status_word[4:0]});
        store_chk(4'h8, 32'ha01);
        store_chk(4'h1, 32'h5a5a0214);
        issue(CPMB_MODE_SET, 4'h0, 4'h0, 32'h0, {27'h0, MODE_SUPERVISOR}, 32'h3);
        store_chk(4'h8, 32'h801);
        store_chk(SP_INDEX, 32'h901);
    endtask : t_bank

    task automatic results;
        $display("comparisons %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results

    initial
    begin
        {reset_n, iss_valid, iss_cond_pass, iss_use_reg, ureg} = 5'h0;
        {iss_rd, iss_rn, iss_rm, iss_cp_num, iss_words} = 21'h0;
        {iss_imm, iss_pc} = 64'h0;
        iss_class = CPMB_NOP;
        {cond, words, cpn} = {1'b1, 5'h4, 4'h9};
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk("status", STATUS_RESET, status_word);
        chk("fetch", FETCH_RESET, fetch_addr);
        t_alu();
        t_flow();
        t_mem();
        t_hazard();
        t_bank();
        repeat (4) @(negedge clk);
        chk("retired", 32'(issued), 32'(retires));
        results();
    end
endmodule : cpmb_core_tb
